//--- src/eepc_pkg.sv
// package: offsets, field positions, reset values and carriers of the nv program control
package eepc_pkg;

  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  OTP_CTRL_OFS    = 8'h2B;
  localparam logic [7:0]  NV_CTRL_OFS     = 8'h3B;
  localparam logic [7:0]  OTP_CTRL_RST    = 8'h00;
  localparam logic [7:0]  NV_CTRL_RST     = 8'h00;

  // ---------------------------------------------------------------
  // eprom_program_control fields
  // ---------------------------------------------------------------
  localparam int          OTP_MBE_BIT     = 7;
  localparam int          OTP_LAT_BIT     = 5;
  localparam int          OTP_XCOL_BIT    = 4;
  localparam int          OTP_XROW_BIT    = 3;
  localparam int          OTP_PGM_BIT     = 0;
  localparam logic [7:0]  OTP_IMPL_MASK   = 8'hB9;  // bits 6, 2, 1 absent
  localparam logic [7:0]  OTP_ANY_MASK    = 8'h21;  // bits usable in every mode

  // ---------------------------------------------------------------
  // eeprom_program_control fields
  // ---------------------------------------------------------------
  localparam int          NV_ODD_BIT      = 7;
  localparam int          NV_EVEN_BIT     = 6;
  localparam int          NV_BYTE_BIT     = 4;
  localparam int          NV_ROW_BIT      = 3;
  localparam int          NV_ERASE_BIT    = 2;
  localparam int          NV_LAT_BIT      = 1;
  localparam int          NV_PGM_BIT      = 0;
  localparam logic [7:0]  NV_IMPL_MASK    = 8'hDF;  // bit 5 absent

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam int          NV_SIZE         = 640;
  localparam int          NV_HALF         = 320;
  localparam int          NV_ROW_BYTES    = 16;
  localparam int          NV_HALF_ROWS    = 20;
  localparam logic [11:0] NV_LOW_OFS      = 12'hD80;
  localparam logic [9:0]  NV_BLK1_START   = 10'h020;
  localparam logic [9:0]  NV_BLK2_START   = 10'h060;
  localparam logic [9:0]  NV_BLK3_START   = 10'h0E0;
  localparam logic [9:0]  NV_BLK4_START   = 10'h200;
  localparam logic [4:0]  XCOL_LOW_ONES   = 5'h1F;
  localparam logic [4:0]  XROW_HIGH_ZERO  = 5'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } eepc_reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } eepc_mem_req_t;

  typedef struct packed {
    logic        bulk;
    logic [4:0]  blk;
  } eepc_prot_t;

  typedef enum logic [1:0] {
    NV_IDLE,
    NV_OPEN,
    NV_HELD,
    NV_HV
  } eepc_nv_state_t;

endpackage : eepc_pkg

//--- src/eepc_top.sv
// eprom and eeprom program control with the arrays it governs
//
// Notes on behaviour
// - unprogrammed eprom bytes read back as all ones.
// - multi-byte enable programs four bytes, address bits 7 and 4 ignored.
// - multi_byte_enable accessible only in special modes, reads zero otherwise.
// - eprom control bits 6, 2 and 1 are absent and read zero.
// - otp latch captures eprom write address and data; eprom unreadable meanwhile.
// - extra column at data bit 7, address bits 11-5, bits 4-0 ones.
// - extra column and row selects only in special modes, else read zero.
// - extra rows use address bits 6-0, bits 11-7 zero, high bits pick block.
// - otp voltage command always readable, writable only while latch set.
// - otp voltage command is zero whenever the otp latch is zero.
// - 640-byte eeprom at 0D80h-0FFFh after reset, remappable, enabled by config.
// - config bit picks the on-chip oscillator for the eeprom charge pump.
// - eeprom writes blocked while voltage on or to another location mid-operation.
// - odd and even set together program all rows of one eeprom half.
// - eeprom control bit 5 is absent and reads zero.
// - byte and row bits select bulk, row or byte erase.
// - erase bit makes eeprom operations erases, else read or program.
// - nv latch sets up program paths; when clear reads ignore protection.
// - block protect bits guard their blocks; bulk protect stops bulk and row erase.
`timescale 1ns/1ps
`default_nettype none

module eepc_top #(
  parameter int          OTP_AW   = 12,        // eprom address width
  parameter logic [15:0] OTP_BASE = 16'hD000   // eprom base address
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire eepc_pkg::eepc_reg_req_t reg_req_i,
  output logic [7:0]                   reg_rdata_o,
  input  wire eepc_pkg::eepc_mem_req_t mem_req_i,
  output logic [7:0]                   mem_rdata_o,
  input  wire logic                    special_mode_i,
  input  wire logic                    nv_array_enable_i,
  input  wire logic                    alt_clock_select_i,
  input  wire logic [3:0]              nv_remap_i,
  input  wire eepc_pkg::eepc_prot_t    prot_i,
  output logic                         otp_supply_on_o,
  output logic                         nv_pump_on_o,
  output logic                         nv_pump_alt_clk_o,
  output logic                         nv_erase_mode_o
);
  import eepc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // block index of an eeprom offset
  function automatic logic [2:0] nv_block(input logic [9:0] ofs);
    logic [2:0] b;
    b = 3'h0;
    if (ofs >= NV_BLK4_START) b = 3'h4;
    else if (ofs >= NV_BLK3_START) b = 3'h3;
    else if (ofs >= NV_BLK2_START) b = 3'h2;
    else if (ofs >= NV_BLK1_START) b = 3'h1;
    return b;
  endfunction : nv_block

  // true when the block holding an offset is protected
  function automatic logic nv_locked(input logic [9:0] ofs, input logic [4:0] blk);
    return blk[nv_block(ofs)];
  endfunction : nv_locked

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]     mode_sync;                   // special mode pin synchroniser
  logic           special;
  logic [7:0]     otp_ctrl;
  logic [7:0]     nv_ctrl;
  logic           otp_pgm_prev;
  logic           nv_pgm_prev;
  logic [15:0]    otp_cap_addr;
  logic [7:0]     otp_cap_data;
  logic           otp_cap_valid;
  logic [9:0]     nv_cap_ofs;
  logic [7:0]     nv_cap_data;
  logic [7:0]     otp_held;                    // eprom mode bits while voltage on
  logic [7:0]     nv_held;                     // eeprom mode bits while voltage on
  eepc_nv_state_t nv_state;
  eepc_nv_state_t next_nv_state;
  logic           alt_clk_q;
  logic [7:0]     reg_rdata;
  logic [7:0]     mem_rdata;

  logic [7:0]     otp_mem  [0:(1<<OTP_AW)-1];
  logic           xcol_mem [0:127];
  logic [7:0]     xrow_mem [0:511];
  logic [7:0]     nv_mem   [0:NV_SIZE-1];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // register selects and writable masks per mode
  wire        otp_reg_sel  = (reg_req_i.addr == OTP_CTRL_OFS);
  wire        nv_reg_sel   = (reg_req_i.addr == NV_CTRL_OFS);
  wire        otp_reg_wr   = reg_req_i.wr && otp_reg_sel;
  wire        nv_reg_wr    = reg_req_i.wr && nv_reg_sel;
  wire [7:0]  otp_wmask    = special ? OTP_IMPL_MASK : OTP_ANY_MASK;
  wire [7:0]  otp_view     = otp_ctrl & otp_wmask;
  wire [7:0]  nv_view      = nv_ctrl & NV_IMPL_MASK;

  // effective control bits
  wire        otp_lat      = otp_ctrl[OTP_LAT_BIT];
  wire        otp_pgm      = otp_ctrl[OTP_PGM_BIT];
  wire        otp_xcol     = otp_view[OTP_XCOL_BIT];
  wire        otp_xrow     = otp_view[OTP_XROW_BIT];
  wire        nv_lat       = nv_ctrl[NV_LAT_BIT];
  wire        nv_pgm       = nv_ctrl[NV_PGM_BIT];

  // operation bits as they stood under voltage; the clearing write lands before the update
  wire        otp_mbe      = otp_held[OTP_MBE_BIT];
  wire        otp_xcol_op  = otp_held[OTP_XCOL_BIT];
  wire        otp_xrow_op  = otp_held[OTP_XROW_BIT];
  wire        nv_erase     = nv_held[NV_ERASE_BIT];
  wire        nv_byte      = nv_held[NV_BYTE_BIT];
  wire        nv_row       = nv_held[NV_ROW_BIT];
  wire        nv_test_both = nv_held[NV_ODD_BIT] && nv_held[NV_EVEN_BIT];

  // next register values: eprom voltage command needs latch now and in the new value, eeprom voltage command only in the new value
  wire [7:0]  otp_wval     = (reg_req_i.wdata & otp_wmask) | (otp_ctrl & ~otp_wmask);
  wire        otp_pgm_ok   = otp_lat && otp_wval[OTP_LAT_BIT];
  wire [7:0]  next_otp     = {otp_wval[7:1], otp_wval[OTP_PGM_BIT] & otp_pgm_ok};
  wire [7:0]  next_nv      = {reg_req_i.wdata[7:1],
                              reg_req_i.wdata[NV_PGM_BIT] & reg_req_i.wdata[NV_LAT_BIT]};

  // memory window hits
  wire [15:0] maddr        = mem_req_i.addr;
  wire        otp_hit      = (maddr[15:OTP_AW] == OTP_BASE[15:OTP_AW]);
  wire [11:0] nv_low       = maddr[11:0] - NV_LOW_OFS;
  wire [9:0]  nv_ofs       = nv_low[9:0];
  wire        nv_hit       = nv_array_enable_i && (maddr[15:12] == nv_remap_i)
                             && (maddr[11:0] >= NV_LOW_OFS);

  // write captures
  wire        otp_cap      = mem_req_i.wr && otp_hit && otp_lat && !otp_pgm;
  wire        nv_same      = (nv_state != NV_HELD) || (nv_ofs == nv_cap_ofs);
  wire        nv_cap       = mem_req_i.wr && nv_hit && nv_lat && !nv_pgm
                             && (nv_state != NV_HV) && nv_same;

  // end of a voltage pulse triggers the cell update; duration is software's
  wire        otp_fire     = otp_pgm_prev && !otp_pgm && otp_cap_valid;
  wire        nv_fire      = nv_pgm_prev && !nv_pgm && (nv_state == NV_HV);

  // extra area address checks
  wire        xcol_ok      = (otp_cap_addr[4:0] == XCOL_LOW_ONES);
  wire        xrow_ok      = (otp_cap_addr[11:7] == XROW_HIGH_ZERO);
  wire [8:0]  xrow_wr_idx  = {otp_cap_addr[13:12], otp_cap_addr[6:0]};
  wire [8:0]  xrow_rd_idx  = {maddr[13:12], maddr[6:0]};

  // eeprom erase scope
  wire        nv_bulk      = !nv_byte && !nv_row;
  wire        nv_rowm      = !nv_byte && nv_row;
  wire [5:0]  nv_row_idx   = nv_cap_ofs[9:4];
  wire        nv_half_hi   = (nv_cap_ofs >= 10'(NV_HALF));

  // ---------------------------------------------------------------
  // read data selection
  // ---------------------------------------------------------------
  // register read path, unmapped offsets read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (otp_reg_sel) begin
      reg_rdata = otp_view;
    end else if (nv_reg_sel) begin
      reg_rdata = nv_view;
    end
  end

  // memory read path; protection plays no part in reads
  always_comb begin
    mem_rdata = ERASED_BYTE;
    if (otp_hit) begin
      if (otp_lat) begin
        mem_rdata = ERASED_BYTE;
      end else if (otp_xcol) begin
        mem_rdata = {xcol_mem[maddr[11:5]], 7'h7F};
      end else if (otp_xrow) begin
        mem_rdata = xrow_mem[xrow_rd_idx];
      end else begin
        mem_rdata = otp_mem[maddr[OTP_AW-1:0]];
      end
    end else if (nv_hit) begin
      mem_rdata = nv_lat ? ERASED_BYTE : nv_mem[nv_ofs];
    end
  end

  // ---------------------------------------------------------------
  // eeprom sequence
  // ---------------------------------------------------------------
  // tracks latch, captured location and voltage phase
  always_comb begin
    next_nv_state = nv_state;
    case (nv_state)
      NV_IDLE: begin
        if (nv_lat) next_nv_state = NV_OPEN;
      end
      NV_OPEN: begin
        if (!nv_lat) next_nv_state = NV_IDLE;
        else if (nv_pgm) next_nv_state = NV_HV;
        else if (nv_cap) next_nv_state = NV_HELD;
      end
      NV_HELD: begin
        if (!nv_lat) next_nv_state = NV_IDLE;
        else if (nv_pgm) next_nv_state = NV_HV;
      end
      NV_HV: begin
        if (!nv_pgm) next_nv_state = nv_lat ? NV_OPEN : NV_IDLE;
      end
      default: next_nv_state = NV_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // control registers and sequencing flops
  // ---------------------------------------------------------------
  // mode pin passes two flops before use
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_sync <= 2'b00;
    end else begin
      mode_sync <= {mode_sync[0], special_mode_i};
    end
  end
  assign special = mode_sync[1];

  // control registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_ctrl <= OTP_CTRL_RST;
      nv_ctrl  <= NV_CTRL_RST;
    end else begin
      if (otp_reg_wr) otp_ctrl <= next_otp;
      if (nv_reg_wr) nv_ctrl <= next_nv;
    end
  end

  // mode bits follow the control registers only while the voltage is on
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_held <= 8'h00;
      nv_held  <= 8'h00;
    end else begin
      if (otp_pgm) otp_held <= otp_view;
      if (nv_pgm) nv_held <= nv_ctrl;
    end
  end

  // pulse edge history, pump clock select and read data
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_pgm_prev <= 1'b0;
      nv_pgm_prev  <= 1'b0;
      alt_clk_q    <= 1'b0;
      reg_rdata_o  <= 8'h00;
      mem_rdata_o  <= 8'h00;
      nv_state     <= NV_IDLE;
    end else begin
      otp_pgm_prev <= otp_pgm;
      nv_pgm_prev  <= nv_pgm;
      alt_clk_q    <= alt_clock_select_i;
      nv_state     <= next_nv_state;
      if (reg_req_i.rd) reg_rdata_o <= reg_rdata;
      if (mem_req_i.rd) mem_rdata_o <= mem_rdata;
    end
  end

  // captured address and data for each array
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      otp_cap_addr  <= 16'h0000;
      otp_cap_data  <= 8'h00;
      otp_cap_valid <= 1'b0;
      nv_cap_ofs    <= 10'h000;
      nv_cap_data   <= 8'h00;
    end else begin
      if (otp_cap) begin
        otp_cap_addr  <= maddr;
        otp_cap_data  <= mem_req_i.wdata;
        otp_cap_valid <= 1'b1;
      end else if (otp_fire || (!otp_lat && !otp_pgm_prev)) begin
        otp_cap_valid <= 1'b0;
      end
      if (nv_cap) begin
        nv_cap_ofs  <= nv_ofs;
        nv_cap_data <= mem_req_i.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // eprom cells and test areas
  // ---------------------------------------------------------------
  // programming only clears bits; a fresh part is all ones
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < (1<<OTP_AW); i++) otp_mem[i] <= ERASED_BYTE;
      for (int i = 0; i < 128; i++) xcol_mem[i] <= 1'b1;
      for (int i = 0; i < 512; i++) xrow_mem[i] <= ERASED_BYTE;
    end else if (otp_fire) begin
      if (otp_xcol_op) begin
        if (xcol_ok) begin
          xcol_mem[otp_cap_addr[11:5]] <= xcol_mem[otp_cap_addr[11:5]]
                                          & otp_cap_data[7];
        end
      end else if (otp_xrow_op) begin
        if (xrow_ok) begin
          xrow_mem[xrow_wr_idx] <= xrow_mem[xrow_wr_idx] & otp_cap_data;
        end
      end else begin
        for (int k = 0; k < 4; k++) begin
          logic [OTP_AW-1:0] a;
          a = otp_cap_addr[OTP_AW-1:0];
          if (otp_mbe) begin
            a[7] = k[1];
            a[4] = k[0];
          end
          if (otp_mbe || k == 0) otp_mem[a] <= otp_mem[a] & otp_cap_data;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // eeprom cells
  // ---------------------------------------------------------------
  // erase sets ones, program clears bits, each gated by protection
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NV_SIZE; i++) nv_mem[i] <= ERASED_BYTE;
    end else if (nv_fire) begin
      if (nv_erase) begin
        if (nv_bulk) begin
          if (!prot_i.bulk && prot_i.blk == 5'h00) begin
            for (int i = 0; i < NV_SIZE; i++) nv_mem[i] <= ERASED_BYTE;
          end
        end else if (nv_rowm) begin
          if (!prot_i.bulk && !nv_locked(nv_cap_ofs, prot_i.blk)) begin
            for (int i = 0; i < NV_ROW_BYTES; i++) begin
              nv_mem[{nv_row_idx, i[3:0]}] <= ERASED_BYTE;
            end
          end
        end else if (!nv_locked(nv_cap_ofs, prot_i.blk)) begin
          nv_mem[nv_cap_ofs] <= ERASED_BYTE;
        end
      end else if (nv_test_both) begin
        for (int r = 0; r < NV_HALF_ROWS; r++) begin
          logic [9:0] t;
          t = 10'(r * NV_ROW_BYTES) + {6'h00, nv_cap_ofs[3:0]};
          if (nv_half_hi) t = t + 10'(NV_HALF);
          if (!nv_locked(t, prot_i.blk)) nv_mem[t] <= nv_mem[t] & nv_cap_data;
        end
      end else if (!nv_locked(nv_cap_ofs, prot_i.blk)) begin
        nv_mem[nv_cap_ofs] <= nv_mem[nv_cap_ofs] & nv_cap_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign otp_supply_on_o   = otp_ctrl[OTP_PGM_BIT];
  assign nv_pump_on_o      = nv_ctrl[NV_PGM_BIT];
  assign nv_pump_alt_clk_o = alt_clk_q;
  assign nv_erase_mode_o   = nv_ctrl[NV_ERASE_BIT];

endmodule : eepc_top

`default_nettype wire

//--- verif/eepc_top_assertions.sv
// assertion checker bound to the nv program control top
`timescale 1ns/1ps
`default_nettype none

module eepc_top_assertions (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire eepc_pkg::eepc_reg_req_t reg_req_i,
  input  wire logic [7:0]              reg_rdata_o,
  input  wire logic                    special_mode_i,
  input  wire logic                    alt_clock_select_i,
  input  wire logic                    otp_supply_on_o,
  input  wire logic                    nv_pump_alt_clk_o,
  input  wire logic                    nv_erase_mode_o
);
  import eepc_pkg::*;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // register accesses
  // ---------------------------------------------------------------
  sequence s_rd_otp;
    reg_req_i.rd && reg_req_i.addr == OTP_CTRL_OFS;
  endsequence
  sequence s_rd_nv;
    reg_req_i.rd && reg_req_i.addr == NV_CTRL_OFS;
  endsequence
  sequence s_wr_otp;
    reg_req_i.wr && reg_req_i.addr == OTP_CTRL_OFS;
  endsequence
  sequence s_wr_nv;
    reg_req_i.wr && reg_req_i.addr == NV_CTRL_OFS;
  endsequence
  // mode settled low long enough to pass the input synchroniser
  sequence s_normal;
    !special_mode_i && !$past(special_mode_i) && !$past(special_mode_i, 2)
      && !$past(special_mode_i, 3);
  endsequence

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_OTP_ABSENT_BITS: assert property (
    s_rd_otp |=> reg_rdata_o[6] == 1'b0 && reg_rdata_o[2:1] == 2'b00)
    else $error("absent eprom control bits read nonzero");
  AST_NV_ABSENT_BIT: assert property (s_rd_nv |=> reg_rdata_o[5] == 1'b0)
    else $error("absent eeprom control bit reads nonzero");
  AST_MBE_NORMAL_ZERO: assert property (
    s_normal ##0 s_rd_otp |=> reg_rdata_o[OTP_MBE_BIT] == 1'b0)
    else $error("multi byte enable visible in normal mode");
  AST_EXTRA_NORMAL_ZERO: assert property (
    s_normal ##0 s_rd_otp |=> reg_rdata_o[4:3] == 2'b00)
    else $error("extra selects visible in normal mode");
  AST_SUPPLY_NEEDS_LATCH: assert property (
    $rose(otp_supply_on_o) |-> $past(reg_req_i.wr) && $past(reg_req_i.addr) == OTP_CTRL_OFS
      && $past(reg_req_i.wdata[OTP_LAT_BIT]) && $past(reg_req_i.wdata[OTP_PGM_BIT]))
    else $error("eprom supply rose without a latched command write");
  AST_SUPPLY_OFF_NO_LATCH: assert property (
    s_wr_otp ##0 !reg_req_i.wdata[OTP_LAT_BIT] |=> !otp_supply_on_o)
    else $error("eprom supply on with latch clear");
  AST_ERASE_MODE: assert property (
    s_wr_nv |=> nv_erase_mode_o == $past(reg_req_i.wdata[NV_ERASE_BIT]))
    else $error("erase mode output does not follow control bit");
  AST_ALT_CLOCK: assert property (
    1'b1 |=> nv_pump_alt_clk_o == $past(alt_clock_select_i))
    else $error("pump clock select does not follow option input");
endmodule : eepc_top_assertions

bind eepc_top eepc_top_assertions eepc_top_assertions_inst (
  .core_clk_i         (core_clk_i),
  .rst_n_i            (rst_n_i),
  .reg_req_i          (reg_req_i),
  .reg_rdata_o        (reg_rdata_o),
  .special_mode_i     (special_mode_i),
  .alt_clock_select_i (alt_clock_select_i),
  .otp_supply_on_o    (otp_supply_on_o),
  .nv_pump_alt_clk_o  (nv_pump_alt_clk_o),
  .nv_erase_mode_o    (nv_erase_mode_o)
);

`default_nettype wire

//--- verif/test_eprom_eeprom_program_control.sv
// self-checking testbench for the nv program control block
`timescale 1ns/1ps
`default_nettype none

module test_eprom_eeprom_program_control;
  import eepc_pkg::*;
  logic          clk;
  logic          rst_n;
  eepc_reg_req_t rq;
  eepc_mem_req_t mq;
  logic [7:0]    rdat;
  logic [7:0]    mdat;
  logic          smode;
  logic          nv_en;
  logic          alt;
  logic [3:0]    remap;
  eepc_prot_t    prot;
  logic          supply;
  logic          alt_o;
  logic          pump;
  logic          erase_o;
  int            fail_count;
  int            comparisons;
  int            cycles;

  eepc_top eepc_top_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_req_i(rq), .reg_rdata_o(rdat),
    .mem_req_i(mq), .mem_rdata_o(mdat), .special_mode_i(smode),
    .nv_array_enable_i(nv_en), .alt_clock_select_i(alt), .nv_remap_i(remap),
    .prot_i(prot), .otp_supply_on_o(supply), .nv_pump_on_o(pump),
    .nv_pump_alt_clk_o(alt_o), .nv_erase_mode_o(erase_o)
  );

  // ---------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // cut the run short if a wait hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rq <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rq <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    rq.rd <= 1'b0;
    #1 check($sformatf("reg %h", a), rdat, exp);
  endtask : rd_reg

  task automatic wr_mem(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mq <= {a, d, 1'b1, 1'b0};
    @(posedge clk);
    mq.wr <= 1'b0;
  endtask : wr_mem

  task automatic rd_mem(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    mq <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    mq.rd <= 1'b0;
    #1 check($sformatf("mem %h", a), mdat, exp);
  endtask : rd_mem

  // latch, store, voltage on, voltage off, then let the array settle
  task automatic prog(input logic [7:0] ofs, input logic [7:0] ctl, input logic [15:0] a,
                      input logic [7:0] d);
    wr_reg(ofs, ctl);
    wr_mem(a, d);
    wr_reg(ofs, ctl | 8'h01);
    wr_reg(ofs, 8'h00);
    repeat (2) @(posedge clk);
  endtask : prog

  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0; rq = '0; mq = '0; smode = 1'b0; nv_en = 1'b1;
    alt = 1'b0; remap = 4'h0; prot = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped offset, normal-mode masking
    rd_reg(OTP_CTRL_OFS, OTP_CTRL_RST);
    rd_reg(NV_CTRL_OFS, NV_CTRL_RST);
    wr_reg(8'h10, 8'hFF);
    rd_reg(8'h10, 8'h00);
    wr_reg(OTP_CTRL_OFS, 8'hFF);
    rd_reg(OTP_CTRL_OFS, 8'h20);
    wr_reg(OTP_CTRL_OFS, 8'h21);
    rd_reg(OTP_CTRL_OFS, 8'h21);
    check("supply", {7'h00, supply}, 8'h01);
    wr_reg(OTP_CTRL_OFS, 8'h01);
    rd_reg(OTP_CTRL_OFS, 8'h00);
    wr_reg(NV_CTRL_OFS, 8'hFF);
    rd_reg(NV_CTRL_OFS, 8'hDF);
    check("erase mode", {7'h00, erase_o}, 8'h01);
    check("pump", {7'h00, pump}, 8'h01);
    wr_reg(NV_CTRL_OFS, 8'h00);
    // eprom program, refused store while unlatched
    rd_mem(16'hD123, ERASED_BYTE);
    wr_mem(16'hD124, 8'h00);
    wr_reg(OTP_CTRL_OFS, 8'h20);
    rd_mem(16'hD123, ERASED_BYTE);
    prog(OTP_CTRL_OFS, 8'h20, 16'hD123, 8'h5A);
    rd_mem(16'hD124, ERASED_BYTE);
    rd_mem(16'hD123, 8'h5A);
    // special mode: multi byte, extra column, extra rows
    @(posedge clk);
    smode <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(OTP_CTRL_OFS, 8'hB8);
    rd_reg(OTP_CTRL_OFS, 8'hB8);
    prog(OTP_CTRL_OFS, 8'hA0, 16'hD099, 8'h3C);
    for (int i = 0; i < 4; i++) rd_mem({8'hD0, i[1], 2'b00, i[0], 4'h9}, 8'h3C);
    rd_mem(16'hD0A9, ERASED_BYTE);
    prog(OTP_CTRL_OFS, 8'h30, 16'hD3FF, 8'h00);
    wr_reg(OTP_CTRL_OFS, 8'h10);
    rd_mem(16'hD3FF, 8'h7F);
    prog(OTP_CTRL_OFS, 8'h28, 16'hD005, 8'h11);
    wr_reg(OTP_CTRL_OFS, 8'h08);
    rd_mem(16'hD005, 8'h11);
    wr_reg(OTP_CTRL_OFS, 8'h00);
    rd_mem(16'hD3FF, ERASED_BYTE);
    rd_mem(16'hD005, ERASED_BYTE);
    smode <= 1'b0;
    repeat (3) @(posedge clk);
    // eeprom program, map, enable
    prog(NV_CTRL_OFS, 8'h02, 16'h0D80, 8'h12);
    rd_mem(16'h0D80, 8'h12);
    remap <= 4'h2;
    rd_mem(16'h2D80, 8'h12);
    remap <= 4'h0;
    nv_en <= 1'b0;
    rd_mem(16'h0D80, ERASED_BYTE);
    nv_en <= 1'b1;
    // refusals while capturing and while voltage is on
    wr_reg(NV_CTRL_OFS, 8'h02);
    wr_mem(16'h0DB0, 8'h0F);
    rd_mem(16'h0DB0, ERASED_BYTE);
    wr_mem(16'h0DB1, 8'h00);
    wr_reg(NV_CTRL_OFS, 8'h03);
    #1 check("pump", {7'h00, pump}, 8'h01);
    wr_mem(16'h0DB0, 8'h00);
    prog(NV_CTRL_OFS, 8'h00, 16'h0000, 8'h00);
    rd_mem(16'h0DB1, ERASED_BYTE);
    rd_mem(16'h0DB0, 8'h0F);
    check("pump", {7'h00, pump}, 8'h00);
    // odd and even rows of one half, block protect
    prog(NV_CTRL_OFS, 8'hC2, 16'h0D83, 8'h00);
    rd_mem(16'h0EB3, 8'h00);
    rd_mem(16'h0EC3, ERASED_BYTE);
    prot.blk <= 5'h01;
    prog(NV_CTRL_OFS, 8'h02, 16'h0D82, 8'h00);
    rd_mem(16'h0D82, ERASED_BYTE);
    // byte, row and bulk erase
    prot.blk <= 5'h00;
    prog(NV_CTRL_OFS, 8'h16, 16'h0D80, 8'h00);
    rd_mem(16'h0D80, ERASED_BYTE);
    rd_mem(16'h0D83, 8'h00);
    prog(NV_CTRL_OFS, 8'h0E, 16'h0D85, 8'h00);
    rd_mem(16'h0D83, ERASED_BYTE);
    rd_mem(16'h0D93, 8'h00);
    prot.bulk <= 1'b1;
    prog(NV_CTRL_OFS, 8'h06, 16'h0DC0, 8'h00);
    rd_mem(16'h0D93, 8'h00);
    prot.bulk <= 1'b0;
    prog(NV_CTRL_OFS, 8'h06, 16'h0DC0, 8'h00);
    rd_mem(16'h0D93, ERASED_BYTE);
    // pump clock option
    alt <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("alt clock", {7'h00, alt_o}, 8'h01);
    wrap_up();
  end
endmodule : test_eprom_eeprom_program_control

`default_nettype wire
